// ### rtl/rnf_top.sv
// Overview of operation
// - Only modems with equal channel_select exchange data.
// - channel_select 0..6 hopping, 0..0x18 single-frequency; one byte, default 0.
// - Single-frequency: 25 channels, 910.5 MHz plus 0.3 MHz per step.
// - Hopping mode hops across the selected channel's frequency group while sending; code steps tx_hop_index_o once per tx_start_i, not tied to the channel.
// - Inactivity counted in 100 ms; reaching the setting arms a long preamble.
// - inactivity_before_preamble of 0xFFFF (default) never sends the long preamble.
// - Receiver in cyclic sleep accepts data only after preamble detect and sync.
// - hardware_version is read-only, two bytes.
// - Foreign vendor_network_number discarded; 0..0x7FFF writable, above read-only.
// - wakeup_preamble_length in 100 ms units, 0..0xFF, default 0x01.
// - Receiver needs about 35 ms of preamble to synchronise.
// - Cyclic sleeper powers down after time_before_sleep idle, wakes periodically; no wake timer here, sleep ends on preamble_detect_i or a mode change.
// - Every sent packet carries our destination_address.
// - Accept if (rx address AND mask) equals our address or our mask.
// - address_mask is 16 bits, default 0xFFFF, meaning exact match.
// - parity_select: 0 none, 1 even, 2 odd, 3 mark, 4 space; default 0.
// - Odd parity rejects even count of ones; even parity the reverse.
// - destination_address 16 bits, default 0.
// - time_before_sleep in 100 ms, range 0x10..0xFFFF, default 0x64.
// - sleep_mode_select: 0 none, 1 pin, 2 serial, 3..8 cyclic 0.5..16 s.
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module rnf_top #(
  parameter int TICK_CYC = rnf_pkg::TICK_CYCLES,
  parameter int SYNC_CYC = rnf_pkg::SYNC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic serial_activity_i,
  input wire logic tx_start_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_channel_i,
  input wire logic [15:0] rx_vendor_i,
  input wire logic [15:0] rx_dest_i,
  input wire logic preamble_detect_i,
  input wire logic char_valid_i,
  input wire logic [8:0] char_bits_i,
  output logic rx_accept_o,
  output logic rx_discard_o,
  output logic tx_long_preamble_o,
  output logic [15:0] tx_dest_o,
  output logic [7:0] tx_hop_index_o,
  output logic tx_hop_mode_o,
  output logic rx_sleep_o,
  output logic rx_synced_o,
  output logic parity_error_o
);
  import rnf_pkg::*;

  initial begin
    if (TICK_CYC < 1 || SYNC_CYC < 1 || TICK_CYC > 2**24 || SYNC_CYC > 2**24) begin
      $error("rnf_top: tick or sync count out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] chan_q, chan_d;
  logic hop_mode_q, hop_mode_d;
  logic [15:0] inact_q, inact_d;
  logic [7:0] pre_len_q, pre_len_d;
  logic [15:0] sleep_time_q, sleep_time_d;
  logic [3:0] sleep_mode_q, sleep_mode_d;
  logic [15:0] mask_q, mask_d;
  logic [15:0] dest_q, dest_d;
  logic [15:0] vendor_q, vendor_d;
  logic [2:0] parity_q, parity_d;
  logic aw_q, aw_d, w_q, w_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wv;
  logic wr_ok;
  logic [15:0] hw_ver;
  logic [19:0] freq_khz;

  assign hw_ver = HW_VER_RST;
  assign freq_khz = FREQ_BASE_KHZ + 20'(FREQ_STEP_KHZ * 20'(chan_q));
  assign wv = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    chan_d = chan_q;
    hop_mode_d = hop_mode_q;
    inact_d = inact_q;
    pre_len_d = pre_len_q;
    sleep_time_d = sleep_time_q;
    sleep_mode_d = sleep_mode_q;
    mask_d = mask_q;
    dest_d = dest_q;
    vendor_d = vendor_q;
    parity_d = parity_q;
    wr_ok = 1'b1;
    if (s_axi_awvalid_i && !aw_q) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_q) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (s_axi_bready_i && bvalid_q) begin
      bvalid_d = 1'b0;
    end
    if (aw_q && w_q && !bvalid_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      // range checks refuse the write and keep the old value
      case (awaddr_q)
        OFF_CHANNEL: begin
          if (wv[7:0] <= (hop_mode_q ? CHAN_HOP_MAX : CHAN_SINGLE_MAX)) begin
            chan_d = wv[7:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
        OFF_INACT: inact_d = wv[15:0];
        OFF_PREAMBLE: pre_len_d = wv[7:0];
        OFF_SLEEP_TIME: begin
          if (wv[15:0] >= SLEEP_TIME_MIN) begin
            sleep_time_d = wv[15:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
        OFF_SLEEP_MODE: begin
          if (wv[31:4] == 28'h0 && wv[3:0] <= SLEEP_MODE_MAX) begin
            sleep_mode_d = wv[3:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
        OFF_MASK: mask_d = wv[15:0];
        OFF_DEST: dest_d = wv[15:0];
        OFF_VENDOR: begin
          if (wv[15:0] <= VENDOR_USER_MAX) begin
            vendor_d = wv[15:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
        OFF_PARITY: begin
          if (wv[7:0] <= 8'(PARITY_MAX)) begin
            parity_d = wv[2:0];
          end else begin
            wr_ok = 1'b0;
          end
        end
        OFF_CONTROL: begin
          // mode change resets the channel, whose range depends on the mode
          hop_mode_d = wv[0];
          if (wv[0] != hop_mode_q) begin
            chan_d = CHAN_RST;
          end
        end
        default: wr_ok = 1'b0; // read-only or unmapped, incl. hardware_version
      endcase
      bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_comb begin
    arready_d = 1'b0;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid_i && !arready_q && !rvalid_q) begin
      arready_d = 1'b1;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr_i)
        OFF_CHANNEL: rdata_d = {24'h0, chan_q};
        OFF_INACT: rdata_d = {16'h0, inact_q};
        OFF_PREAMBLE: rdata_d = {24'h0, pre_len_q};
        OFF_SLEEP_TIME: rdata_d = {16'h0, sleep_time_q};
        OFF_SLEEP_MODE: rdata_d = {28'h0, sleep_mode_q};
        OFF_MASK: rdata_d = {16'h0, mask_q};
        OFF_DEST: rdata_d = {16'h0, dest_q};
        OFF_VENDOR: rdata_d = {16'h0, vendor_q};
        OFF_HW_VER: rdata_d = {16'h0, hw_ver};
        OFF_PARITY: rdata_d = {29'h0, parity_q};
        OFF_CONTROL: rdata_d = {31'h0, hop_mode_q};
        OFF_STATUS: rdata_d = {28'h0, parity_error_o, tx_long_preamble_o, rx_synced_o, rx_sleep_o};
        OFF_FREQ: rdata_d = {12'h0, hop_mode_q ? 20'h0 : freq_khz};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
      chan_q <= CHAN_RST;
      hop_mode_q <= 1'b1;
      inact_q <= INACT_RST;
      pre_len_q <= PREAMBLE_RST;
      sleep_time_q <= SLEEP_TIME_RST;
      sleep_mode_q <= SLEEP_MODE_RST;
      mask_q <= MASK_RST;
      dest_q <= DEST_RST;
      vendor_q <= VENDOR_RST;
      parity_q <= PARITY_RST;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      chan_q <= chan_d;
      hop_mode_q <= hop_mode_d;
      inact_q <= inact_d;
      pre_len_q <= pre_len_d;
      sleep_time_q <= sleep_time_d;
      sleep_mode_q <= sleep_mode_d;
      mask_q <= mask_d;
      dest_q <= dest_d;
      vendor_q <= vendor_d;
      parity_q <= parity_d;
    end
  end

  assign s_axi_awready_o = !aw_q;
  assign s_axi_wready_o = !w_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // link state: 100 ms tick, inactivity, sleep, sync, filtering, parity
  typedef enum logic [1:0] {RNF_AWAKE, RNF_SLEEP, RNF_SYNCING} rnf_rx_t;
  rnf_rx_t rx_st_q, rx_st_d;
  logic [23:0] tick_q, tick_d;
  logic [15:0] idle_q, idle_d;
  logic [23:0] sync_q, sync_d;
  logic long_pre_q, long_pre_d;
  logic acc_q, acc_d, dis_q, dis_d, perr_q, perr_d;
  logic [7:0] hop_q, hop_d;
  logic tick, activity, cyclic, pass_chan, pass_vid, pass_addr;
  logic [15:0] anded;

  assign tick = (tick_q == 24'(TICK_CYC - 1));
  assign activity = serial_activity_i || tx_start_i || rx_valid_i;
  assign cyclic = (sleep_mode_q >= SLEEP_CYCLIC_MIN);
  assign anded = rx_dest_i & mask_q;
  assign pass_chan = (rx_channel_i == chan_q);
  assign pass_vid = (rx_vendor_i == vendor_q);
  assign pass_addr = (anded == dest_q) || (anded == mask_q);

  always_comb begin
    tick_d = tick ? 24'h0 : tick_q + 24'h1;
    idle_d = idle_q;
    if (activity) begin
      idle_d = 16'h0;
    end else if (tick && idle_q != 16'hFFFF) begin
      idle_d = idle_q + 16'h1;
    end
    long_pre_d = long_pre_q;
    if (tx_start_i) begin
      long_pre_d = 1'b0; // taken by this transmission
    end else if (inact_q != INACT_NEVER && idle_q >= inact_q) begin
      long_pre_d = 1'b1;
    end
    hop_d = hop_q;
    if (tx_start_i && hop_mode_q) begin
      hop_d = hop_q + 8'h1;
    end
    rx_st_d = rx_st_q;
    sync_d = 24'h0;
    case (rx_st_q)
      RNF_AWAKE: begin
        if (cyclic && !activity && idle_q >= sleep_time_q) begin
          rx_st_d = RNF_SLEEP;
        end
      end
      RNF_SLEEP: begin
        if (!cyclic) begin
          rx_st_d = RNF_AWAKE;
        end else if (preamble_detect_i) begin
          rx_st_d = RNF_SYNCING;
        end
      end
      RNF_SYNCING: begin
        if (!preamble_detect_i) begin
          rx_st_d = RNF_SLEEP;
        end else if (sync_q == 24'(SYNC_CYC - 1)) begin
          rx_st_d = RNF_AWAKE;
        end else begin
          sync_d = sync_q + 24'h1;
        end
      end
      default: rx_st_d = RNF_AWAKE;
    endcase
    acc_d = 1'b0;
    dis_d = 1'b0;
    if (rx_valid_i) begin
      // channel, vendor, address in order; sleeping receiver drops all
      if (rx_st_q != RNF_AWAKE) begin
        dis_d = 1'b1;
      end else if (!pass_chan || !pass_vid || !pass_addr) begin
        dis_d = 1'b1;
      end else begin
        acc_d = 1'b1;
      end
    end
    perr_d = perr_q;
    if (char_valid_i) begin
      case (parity_q)
        PAR_EVEN: perr_d = ^char_bits_i;
        PAR_ODD: perr_d = ~^char_bits_i;
        PAR_MARK: perr_d = !char_bits_i[8];
        PAR_SPACE: perr_d = char_bits_i[8];
        default: perr_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_q <= 24'h0;
      idle_q <= 16'h0;
      long_pre_q <= 1'b0;
      hop_q <= 8'h0;
      rx_st_q <= RNF_AWAKE;
      sync_q <= 24'h0;
      acc_q <= 1'b0;
      dis_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      idle_q <= idle_d;
      long_pre_q <= long_pre_d;
      hop_q <= hop_d;
      rx_st_q <= rx_st_d;
      sync_q <= sync_d;
      acc_q <= acc_d;
      dis_q <= dis_d;
      perr_q <= perr_d;
    end
  end

  assign rx_accept_o = acc_q;
  assign rx_discard_o = dis_q;
  assign tx_long_preamble_o = long_pre_q;
  assign tx_dest_o = dest_q;
  assign tx_hop_index_o = hop_mode_q ? hop_q : chan_q;
  assign tx_hop_mode_o = hop_mode_q;
  assign rx_sleep_o = (rx_st_q == RNF_SLEEP);
  assign rx_synced_o = (rx_st_q == RNF_AWAKE);
  assign parity_error_o = perr_q;
endmodule

// ### rtl/rnf_pkg.sv
package rnf_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CHANNEL = 8'h00;
  localparam logic [7:0] OFF_INACT = 8'h04;
  localparam logic [7:0] OFF_PREAMBLE = 8'h08;
  localparam logic [7:0] OFF_SLEEP_TIME = 8'h0C;
  localparam logic [7:0] OFF_SLEEP_MODE = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_DEST = 8'h18;
  localparam logic [7:0] OFF_VENDOR = 8'h1C;
  localparam logic [7:0] OFF_HW_VER = 8'h20;
  localparam logic [7:0] OFF_PARITY = 8'h24;
  localparam logic [7:0] OFF_CONTROL = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_FREQ = 8'h30;

  // ranges and reset values
  localparam logic [7:0] CHAN_HOP_MAX = 8'h06;
  localparam logic [7:0] CHAN_SINGLE_MAX = 8'h18;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [15:0] INACT_RST = 16'hFFFF;
  localparam logic [15:0] INACT_NEVER = 16'hFFFF;
  localparam logic [7:0] PREAMBLE_RST = 8'h01;
  localparam logic [15:0] SLEEP_TIME_MIN = 16'h0010;
  localparam logic [15:0] SLEEP_TIME_RST = 16'h0064;
  localparam logic [3:0] SLEEP_MODE_MAX = 4'h8;
  localparam logic [3:0] SLEEP_MODE_RST = 4'h0;
  localparam logic [3:0] SLEEP_CYCLIC_MIN = 4'h3;
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [15:0] DEST_RST = 16'h0000;
  localparam logic [15:0] VENDOR_USER_MAX = 16'h7FFF;
  localparam logic [15:0] VENDOR_RST = 16'h1234; // arbitrary value
  localparam logic [15:0] HW_VER_RST = 16'h0A01; // arbitrary value
  localparam logic [2:0] PARITY_MAX = 3'h4;
  localparam logic [2:0] PARITY_RST = 3'h0;

  // parity encodings
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;

  // single-frequency plan in kHz: base plus step times channel
  localparam logic [19:0] FREQ_BASE_KHZ = 20'd910500;
  localparam logic [19:0] FREQ_STEP_KHZ = 20'd300;

  // time bases
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int SYNC_US = 35000;
  localparam int SYNC_CYCLES = (CLK_HZ / 1000000) * SYNC_US;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### testbench/rnf_top_sva.sv
module rnf_top_sva #(
  parameter int TICK_CYC = 10,
  parameter int SYNC_CYC = 5
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic rx_valid_i,
  input wire logic preamble_detect_i,
  input wire logic rx_accept_o,
  input wire logic rx_discard_o,
  input wire logic rx_sleep_o,
  input wire logic rx_synced_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////////
  AST_FILT_LAT: assert property (rx_valid_i |=> rx_accept_o != rx_discard_o)
    else $error("filter verdict missing or doubled");
  AST_NO_SPUR: assert property ((rx_accept_o || rx_discard_o) |-> $past(rx_valid_i))
    else $error("filter verdict without a packet");
  AST_ACC_AWAKE: assert property (rx_accept_o |-> $past(rx_synced_o))
    else $error("packet accepted while not synchronised");
  // a sleeper hearing no preamble may only stay asleep or wake by mode change
  AST_SLEEP_SYNC: assert property (rx_sleep_o && !preamble_detect_i |=>
    rx_sleep_o || rx_synced_o)
    else $error("left sleep without a wake preamble");
  // both halves of the write accepted in one cycle must be answered within two cycles
  AST_WR_ANS: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o && !s_axi_bvalid_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  AST_BV_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_RD_ANS: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
    |=> s_axi_arready_o && s_axi_rvalid_o)
    else $error("read answer late");
  AST_RV_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_AR_PULSE: assert property (s_axi_arready_o |=> !s_axi_arready_o)
    else $error("arready longer than one cycle");
endmodule

bind rnf_top rnf_top_sva #(.TICK_CYC(TICK_CYC), .SYNC_CYC(SYNC_CYC)) i_rnf_top_sva (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .rx_valid_i(rx_valid_i), .rx_accept_o(rx_accept_o),
  .rx_discard_o(rx_discard_o), .rx_sleep_o(rx_sleep_o), .rx_synced_o(rx_synced_o),
  .preamble_detect_i(preamble_detect_i));

// ### testbench/rnf_peer.sv
module rnf_peer (
  input wire logic mclk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_channel_o,
  output logic [15:0] rx_vendor_o,
  output logic [15:0] rx_dest_o,
  output logic preamble_detect_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_channel_o = 8'h00;
    rx_vendor_o = 16'h0000;
    rx_dest_o = 16'h0000;
    preamble_detect_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // header carries the sender's own channel, vendor and address; garbage after
  task automatic send(input logic [7:0] c, input logic [15:0] v, input logic [15:0] d);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_channel_o <= c;
    rx_vendor_o <= v;
    rx_dest_o <= d;
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_channel_o <= ~c;
    rx_vendor_o <= ~v;
    rx_dest_o <= ~d;
  endtask
  // long pattern so that a sleeper waking late still hears enough of it
  task automatic preamble(input int n);
    @(posedge mclk_i);
    preamble_detect_o <= 1'b1;
    repeat (n) @(posedge mclk_i);
    preamble_detect_o <= 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rnf_pkg::*;
  localparam int TK = 10;
  localparam int SY = 5;
  localparam logic [7:0] WA [16] = '{8'h00, 8'h00, 8'h08, 8'h0C, 8'h0C, 8'h10, 8'h10, 8'h24,
    8'h24, 8'h1C, 8'h1C, 8'h20, 8'h28, 8'h00, 8'h00, 8'h30};
  localparam int WV [16] = '{6, 7, 255, 15, 16, 9, 2, 5, 4, 32768, 32767, 21845, 0, 25, 24, 0};
  logic mclk_i, reset_n_i, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, act, txs, rxv, pre, chv, acc, dis, lpre, hmode, slp;
  logic syn, perr;
  logic [7:0] awaddr, araddr, rxc, hidx;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] rxvend, rxdest, tdest;
  logic [8:0] chb;
  int num_errors, samples_checked;
  int m [13];
  bit awake;

  rnf_top #(.TICK_CYC(TK), .SYNC_CYC(SY)) i_rnf_top (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .serial_activity_i(act), .tx_start_i(txs), .rx_valid_i(rxv), .rx_channel_i(rxc),
    .rx_vendor_i(rxvend), .rx_dest_i(rxdest), .preamble_detect_i(pre), .char_valid_i(chv),
    .char_bits_i(chb), .rx_accept_o(acc), .rx_discard_o(dis), .tx_long_preamble_o(lpre),
    .tx_dest_o(tdest), .tx_hop_index_o(hidx), .tx_hop_mode_o(hmode), .rx_sleep_o(slp),
    .rx_synced_o(syn), .parity_error_o(perr));
  rnf_peer i_rnf_peer (.mclk_i(mclk_i), .rx_valid_o(rxv), .rx_channel_o(rxc),
    .rx_vendor_o(rxvend), .rx_dest_o(rxdest), .preamble_detect_o(pre));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ready is up early only at random, so the hold paths get exercised too
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom);
    for (int n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
      if (bvalid) bready <= 1'b1;
    end
    num_errors++;
    $display("[ERR] write response missing");
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom);
    for (int n = 0; n < 100; n++) begin
      @(posedge mclk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
      if (rvalid) rready <= 1'b1;
    end
    num_errors++;
    $display("[ERR] read answer missing");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic bit legal(int i, int v);
    case (i)
      0: return v <= (m[10] ? 6 : 24);
      2: return v <= 255;
      3: return v >= 16;
      4: return v <= 8;
      7: return v <= 32767;
      8, 11, 12: return 0;
      9: return v <= 4;
      10: return v <= 1;
      default: return 1;
    endcase
  endfunction
  function automatic int exp_rd(int i);
    if (i == 12) return m[10] ? 0 : 910500 + 300 * m[0];
    return m[i];
  endfunction
  task automatic wr_chk(input logic [7:0] a, input int v);
    logic [1:0] r;
    logic [31:0] d;
    bit ok;
    ok = legal(a >> 2, v);
    axi_write(a, 32'(v), r);
    check("bresp", ok ? RESP_OKAY : RESP_SLVERR, 32'(r));
    if (ok) m[a >> 2] = v;
    // leaving a channel mode drops the channel back to zero
    if (ok && a == OFF_CONTROL) m[0] = 0;
    axi_read(a, d, r);
    check("readback", exp_rd(a >> 2), d);
  endtask
  task automatic send_chk(input logic [7:0] c, input logic [15:0] v, input logic [15:0] d);
    logic [15:0] am;
    bit hit;
    am = d & 16'(m[5]);
    hit = awake && c == 8'(m[0]) && v == 16'(m[7]) && (am == 16'(m[6]) || am == 16'(m[5]));
    i_rnf_peer.send(c, v, d);
    #1;
    check("accept", 32'(hit), 32'(acc));
    check("discard", 32'(!hit), 32'(dis));
  endtask
  task automatic pulse();
    @(posedge mclk_i);
    act <= 1'b1;
    txs <= 1'b1;
    @(posedge mclk_i);
    act <= 1'b0;
    txs <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    $display("[ERR] watchdog expired");
    final_report();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [8:0] b;
    logic [7:0] c;
    logic [15:0] v, a;
    int e, s;
    {awvalid, wvalid, bready, arvalid, rready, act, txs, chv, reset_n_i} = '0;
    {awaddr, araddr, wdata, chb} = '0;
    wstrb = 4'hF;
    num_errors = 0;
    samples_checked = 0;
    m = '{0, 16'hFFFF, 1, 16'h0064, 0, 16'hFFFF, 0, VENDOR_RST, HW_VER_RST, 0, 1, 0, 0};
    awake = 1'b1;
    void'($urandom(32'hF5F0C4B0));
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      axi_read(8'(i * 4), d, r);
      check("reset value", 32'(m[i]), d);
    end
    axi_read(8'h40, d, r);
    check("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    check("unmapped data", 32'h0, d);
    // hopping mode out of reset: one hop per transmission start
    pulse();
    #1 check("hop index", 32'h1, 32'(hidx));
    for (int i = 0; i < 16; i++) begin
      wr_chk(WA[i], WV[i]);
    end
    check("hop mode", 32'h0, 32'(hmode));
    check("single channel", 32'h18, 32'(hidx));
    for (int k = 0; k < 2; k++) begin
      if (k) wr_chk(OFF_MASK, $urandom % 65536);
      wr_chk(OFF_DEST, $urandom % 65536);
      #1 check("tx dest", 32'(m[6]), 32'(tdest));
      repeat (30) begin
        c = ($urandom % 4) ? 8'(m[0]) : 8'(m[0] + 1);
        v = ($urandom % 4) ? 16'(m[7]) : 16'($urandom);
        s = $urandom % 3;
        a = (s == 0) ? 16'(m[6]) : (s == 1) ? 16'(m[5]) | 16'($urandom) : 16'($urandom);
        send_chk(c, v, a);
      end
    end
    for (int p = 0; p <= 4; p++) begin
      wr_chk(OFF_PARITY, p);
      repeat (8) begin
        b = 9'($urandom);
        @(posedge mclk_i);
        chv <= 1'b1;
        chb <= b;
        @(posedge mclk_i);
        chv <= 1'b0;
        chb <= ~b;
        #1;
        e = (p == 1) ? $countones(b) % 2 : (p == 2) ? 1 - $countones(b) % 2 : 0;
        e = (p == 3) ? !b[8] : (p == 4) ? b[8] : e;
        check("parity error", 32'(e), 32'(perr));
      end
    end
    // base delay kept shorter than the sleeper's idle time
    wr_chk(OFF_INACT, 2);
    pulse();
    repeat (3) @(posedge mclk_i);
    #1 check("early preamble", 32'h0, 32'(lpre));
    repeat (35) @(posedge mclk_i);
    #1 check("long preamble", 32'h1, 32'(lpre));
    wr_chk(OFF_INACT, 16'hFFFF);
    pulse();
    repeat (60) @(posedge mclk_i);
    #1 check("never preamble", 32'h0, 32'(lpre));
    wr_chk(OFF_SLEEP_MODE, 3);
    repeat (16 * TK + 40) @(posedge mclk_i);
    #1 check("asleep", 32'h1, 32'(slp));
    // status: last parity verdict, no long preamble, not synced, asleep
    axi_read(OFF_STATUS, d, r);
    check("status", 32'(e * 8 + 1), d);
    awake = 1'b0;
    send_chk(8'(m[0]), 16'(m[7]), 16'(m[5]));
    @(posedge mclk_i);
    act <= 1'b1;
    i_rnf_peer.preamble(SY + 4);
    #1 check("synced", 32'h1, 32'(syn));
    awake = 1'b1;
    send_chk(8'(m[0]), 16'(m[7]), 16'(m[5]));
    @(posedge mclk_i);
    act <= 1'b0;
    repeat (5) @(posedge mclk_i);
    final_report();
  end
endmodule
